/* verilog/rom_pkg.sv */
// Purpose: Shared constants and types for the regulator output monitor.
// Assumes: Eight-bit registers on a nine-bit register address port.
// Notes:   Slots number the eleven monitored regulators 0..10.
`default_nettype none
package rom_pkg;

	// Register addresses
	localparam logic [8:0] ROM_ADDR_CFG    = 9'h114;
	localparam logic [8:0] ROM_ADDR_EN_A   = 9'h115;
	localparam logic [8:0] ROM_ADDR_EN_B   = 9'h116;
	localparam logic [8:0] ROM_ADDR_EN_C   = 9'h117;
	localparam logic [8:0] ROM_ADDR_IDX_AB = 9'h11e;
	localparam logic [8:0] ROM_ADDR_IDX_C  = 9'h11f;

	// Values after reset
	localparam logic [7:0] ROM_CFG_RST   = 8'h00;
	localparam logic [7:0] ROM_EN_RST    = 8'h00;
	localparam logic [2:0] ROM_IDX_RST   = 3'h0;
	localparam logic [7:0] ROM_RDATA_RST = 8'h00;

	// Field positions in the configuration register
	localparam int ROM_DELAY_HI = 7;
	localparam int ROM_DELAY_LO = 6;
	localparam int ROM_MODE_HI  = 5;
	localparam int ROM_MODE_LO  = 4;
	localparam int ROM_DEB_BIT  = 3;
	localparam int ROM_RES_BIT  = 2;
	localparam int ROM_THR_HI   = 1;
	localparam int ROM_THR_LO   = 0;

	// Measurements skipped after enable, per delay code
	localparam logic [2:0] ROM_DLY_CNT0 = 3'h0;
	localparam logic [2:0] ROM_DLY_CNT1 = 3'h1;
	localparam logic [2:0] ROM_DLY_CNT2 = 3'h2;
	localparam logic [2:0] ROM_DLY_CNT3 = 3'h4;

	// Window: 25 % is a shift by two, each code halves it
	localparam logic [2:0] ROM_THR_BASE_SHIFT = 3'h2;

	localparam int         ROM_NUM_REG = 11;
	localparam logic [3:0] ROM_SLOT_NONE = 4'hf;

	// Monitor channels
	localparam logic [1:0] ROM_CH_FIRST  = 2'h0;
	localparam logic [1:0] ROM_CH_SECOND = 2'h1;
	localparam logic [1:0] ROM_CH_THIRD  = 2'h2;

	typedef enum logic [1:0] {
		ROM_MODE_LOCKOUT = 2'h0,
		ROM_MODE_NORMAL  = 2'h1,
		ROM_MODE_BURST   = 2'h2,
		ROM_MODE_RSVD    = 2'h3
	} rom_mode_t;

	// One finished conversion from the converter
	typedef struct packed {
		logic [1:0] chan;
		logic [2:0] idx;
		logic [7:0] value;
		logic [7:0] target;
	} rom_meas_t;

endpackage
`default_nettype wire

/* verilog/rom_monitor.sv */
// Purpose: Regulator output monitor with lockout, auto and burst modes.
// Assumes: Converter results and regulator states arrive on ref_clk_in.
// Notes:   Summary of operation below; modes are a field, not a machine.
//
// Summary of operation
// (R1) Range checks start 0, 1, 2 or 4 measurements after regulator enable.
// (R2) Mode 00: out-of-range raises event, interrupt and shuts regulator.
// (R3) Mode 01: any finished auto measurement raises event and interrupt.
// (R4) Mode 10: event only after third channel slot done; 11 reserved.
// (R5) Debounce bit off or on for all three monitor channels.
// (R6) Reset output asserts on out-of-range if reset bit and mask set.
// (R7) Threshold code picks window 25, 12.5, 6.25 or 3.125 percent.
// (R8) Only regulators with their enable bit set are counted and range checked.
// (R9) Each channel reports last measured regulator index, 000 for none.
// (R10) Event flag sticks until cleared; unmasked flag holds interrupt low.
`timescale 1ns/1ps
`default_nettype none
module rom_monitor
	import rom_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                   ref_clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   ce_in,
	// Register port
	input  wire logic [8:0]             reg_addr_in,
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	input  wire logic [7:0]             reg_wdata_in,
	output logic      [7:0]             reg_rdata_out,
	// Converter results
	input  wire logic                   meas_valid_in,
	input  wire rom_meas_t              meas_in,
	input  wire logic                   burst_slot_done_in,
	// Regulators
	input  wire logic [ROM_NUM_REG-1:0] regulator_on_in,
	output logic      [ROM_NUM_REG-1:0] regulator_shutdown_out,
	// Event and system outputs
	input  wire logic                   range_violation_mask_in,
	input  wire logic                   event_clear_in,
	output logic                        range_violation_event_out,
	output logic                        interrupt_out_n,
	output logic                        system_reset_out_n
);
	default clocking cb_mon @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	// Regulator slot from channel and index, none if reserved
	function automatic logic [3:0] slot_of(logic [1:0] ch, logic [2:0] idx);
		case ({ch, idx})
			5'h01: slot_of = 4'h0;
			5'h02: slot_of = 4'h1;
			5'h03: slot_of = 4'h2;
			5'h04: slot_of = 4'h3;
			5'h06: slot_of = 4'h4;
			5'h09: slot_of = 4'h5;
			5'h0a: slot_of = 4'h6;
			5'h0b: slot_of = 4'h7;
			5'h12: slot_of = 4'h8;
			5'h13: slot_of = 4'h9;
			5'h14: slot_of = 4'ha;
			default: slot_of = ROM_SLOT_NONE;
		endcase
	endfunction

	// Measurements to skip for a delay code
	function automatic logic [2:0] delay_need(logic [1:0] code);
		case (code)
			2'h0: delay_need = ROM_DLY_CNT0;
			2'h1: delay_need = ROM_DLY_CNT1;
			2'h2: delay_need = ROM_DLY_CNT2;
			default: delay_need = ROM_DLY_CNT3;
		endcase
	endfunction

	logic [7:0]             cfg;
	logic [7:0]             en_a;
	logic [7:0]             en_b;
	logic [7:0]             en_c;
	logic [2:0]             idx_first;
	logic [2:0]             idx_second;
	logic [2:0]             idx_third;
	logic [2:0]             meas_cnt [ROM_NUM_REG];
	logic [ROM_NUM_REG-1:0] deb_pend;
	logic [ROM_NUM_REG-1:0] slot_enabled;
	logic                   event_flag;
	rom_mode_t              mode;
	logic [3:0]             slot;
	logic                   slot_ok;
	logic                   armed;
	logic [7:0]             diff;
	logic [7:0]             limit;
	logic                   out_rng;
	logic                   viol_hit;
	logic                   ev_hit;

	assign mode = rom_mode_t'(cfg[ROM_MODE_HI:ROM_MODE_LO]);

	// Per-slot enable bits gathered from the three enable registers
	assign slot_enabled = {en_b[0], en_a[7], en_a[6], en_c[7], en_c[6],
		en_c[5], en_b[2], en_a[2], en_c[4], en_c[3], en_c[2]};

	// Decode and window check of the incoming measurement
	assign slot    = slot_of(meas_in.chan, meas_in.idx);
	assign slot_ok = meas_valid_in && (slot != ROM_SLOT_NONE) &&
		slot_enabled[slot] && regulator_on_in[slot]; // [R8]
	assign armed   = slot_ok && (meas_cnt[slot] >=
		delay_need(cfg[ROM_DELAY_HI:ROM_DELAY_LO])); // [R1]
	assign diff    = (meas_in.value > meas_in.target) ?
		meas_in.value - meas_in.target : meas_in.target - meas_in.value;
	assign limit   = meas_in.target >> (ROM_THR_BASE_SHIFT +
		{1'b0, cfg[ROM_THR_HI:ROM_THR_LO]}); // [R7]
	assign out_rng = armed && (diff > limit);
	// With debounce on, two violations in a row are needed
	assign viol_hit = out_rng && (mode != ROM_MODE_RSVD) &&
		(!cfg[ROM_DEB_BIT] || deb_pend[slot]); // [R5]

	// Event source picked by the mode; reserved mode raises nothing
	always_comb begin
		case (mode)
			ROM_MODE_LOCKOUT: ev_hit = viol_hit; // [R2]
			ROM_MODE_NORMAL: ev_hit = meas_valid_in &&
				(meas_in.chan <= ROM_CH_THIRD); // [R3]
			ROM_MODE_BURST: ev_hit = burst_slot_done_in; // [R4]
			default: ev_hit = 1'b0; // [R4]
		endcase
	end

	// Writable registers
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			cfg  <= ROM_CFG_RST;
			en_a <= ROM_EN_RST;
			en_b <= ROM_EN_RST;
			en_c <= ROM_EN_RST;
		end else if (ce_in && reg_wr_in) begin
			case (reg_addr_in)
				ROM_ADDR_CFG: cfg <= reg_wdata_in;
				ROM_ADDR_EN_A: en_a <= reg_wdata_in;
				ROM_ADDR_EN_B: en_b <= reg_wdata_in;
				ROM_ADDR_EN_C: en_c <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// Read data registered; unmapped addresses read zero
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= ROM_RDATA_RST;
		end else if (ce_in && reg_rd_in) begin
			case (reg_addr_in)
				ROM_ADDR_CFG: reg_rdata_out <= cfg;
				ROM_ADDR_EN_A: reg_rdata_out <= en_a;
				ROM_ADDR_EN_B: reg_rdata_out <= en_b;
				ROM_ADDR_EN_C: reg_rdata_out <= en_c;
				ROM_ADDR_IDX_AB: reg_rdata_out <=
					{1'b0, idx_second, 1'b0, idx_first};
				ROM_ADDR_IDX_C: reg_rdata_out <= {5'h00, idx_third};
				default: reg_rdata_out <= ROM_RDATA_RST;
			endcase
		end
	end

	// Latest measured regulator per channel, kept even if unmonitored
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			idx_first  <= ROM_IDX_RST;
			idx_second <= ROM_IDX_RST;
			idx_third  <= ROM_IDX_RST;
		end else if (ce_in && meas_valid_in) begin
			case (meas_in.chan)
				ROM_CH_FIRST: idx_first <= meas_in.idx; // [R9]
				ROM_CH_SECOND: idx_second <= meas_in.idx; // [R9]
				ROM_CH_THIRD: idx_third <= meas_in.idx; // [R9]
				default: ;
			endcase
		end
	end

	// Per-slot delay counter, debounce memory and shutdown output
	generate
		for (genvar s = 0; s < ROM_NUM_REG; s++) begin : g_slot
			// Counter restarts whenever the regulator is off
			always_ff @(posedge ref_clk_in) begin
				if (!rst_n_in) begin
					meas_cnt[s] <= ROM_DLY_CNT0;
				end else if (ce_in) begin
					if (!regulator_on_in[s]) begin
						meas_cnt[s] <= ROM_DLY_CNT0; // [R1]
					end else if (slot_ok && slot == 4'(s) &&
						meas_cnt[s] < ROM_DLY_CNT3) begin
						meas_cnt[s] <= meas_cnt[s] + 3'h1; // [R1]
					end
				end
			end
			// Pending hit dropped by in-range result or regulator off
			always_ff @(posedge ref_clk_in) begin
				if (!rst_n_in) begin
					deb_pend[s] <= 1'b0;
				end else if (ce_in && (!regulator_on_in[s] ||
					(armed && slot == 4'(s)))) begin
					deb_pend[s] <= out_rng && regulator_on_in[s]; // [R5]
				end
			end
			// Shutdown holds until the regulator reports off
			always_ff @(posedge ref_clk_in) begin
				if (!rst_n_in) begin
					regulator_shutdown_out[s] <= 1'b0;
				end else if (ce_in) begin
					if (mode == ROM_MODE_LOCKOUT && viol_hit &&
						slot == 4'(s)) begin
						regulator_shutdown_out[s] <= 1'b1; // [R2]
					end else if (!regulator_on_in[s]) begin
						regulator_shutdown_out[s] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Sticky event; a new event beats a clear in the same cycle
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			event_flag <= 1'b0;
		end else if (ce_in) begin
			if (ev_hit) begin
				event_flag <= 1'b1; // [R10]
			end else if (event_clear_in) begin
				event_flag <= 1'b0;
			end
		end
	end

	// One-cycle reset pulse per detection, only when both bits allow it
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			system_reset_out_n <= 1'b1;
		end else if (ce_in) begin
			system_reset_out_n <= !(viol_hit && cfg[ROM_RES_BIT] &&
				range_violation_mask_in); // [R6]
		end
	end

	assign range_violation_event_out = event_flag;
	// Interrupt is a level while the flag stands unmasked
	assign interrupt_out_n = !(event_flag && range_violation_mask_in); // [R10]
	sequence s_event_unmasked;
		ce_in && ev_hit && range_violation_mask_in
		##1 range_violation_mask_in;
	endsequence
	chk_event_set: assert property ( // [R10]
		ce_in && ev_hit |=> event_flag) else $error("event not latched");
	chk_event_hold: assert property ( // [R10]
		ce_in && event_flag && !event_clear_in |=> event_flag)
		else $error("event flag dropped without clear");
	chk_irq_level: assert property ( // [R10]
		s_event_unmasked |-> !interrupt_out_n)
		else $error("interrupt not asserted");
	chk_lockout_shut: assert property ( // [R2]
		ce_in && mode == ROM_MODE_LOCKOUT && viol_hit
		|=> regulator_shutdown_out[$past(slot)])
		else $error("regulator not shut down");
	chk_normal_event: assert property ( // [R3]
		ce_in && mode == ROM_MODE_NORMAL && meas_valid_in &&
		meas_in.chan == ROM_CH_SECOND |=> event_flag)
		else $error("auto measurement raised no event");
	chk_burst_quiet: assert property ( // [R4]
		ce_in && mode == ROM_MODE_BURST && !burst_slot_done_in &&
		!event_flag |=> !event_flag)
		else $error("burst event before third slot");
	chk_reset_pulse: assert property ( // [R6]
		ce_in && viol_hit && cfg[ROM_RES_BIT] && range_violation_mask_in
		|=> !system_reset_out_n)
		else $error("reset output not asserted");
	chk_reset_gated: assert property ( // [R6]
		ce_in && !range_violation_mask_in |=> system_reset_out_n)
		else $error("reset asserted while masked");
	chk_delay_gate: assert property ( // [R1]
		slot_ok && meas_cnt[slot] <
		delay_need(cfg[ROM_DELAY_HI:ROM_DELAY_LO]) |-> !viol_hit)
		else $error("range checked during enable delay");
	chk_disabled_slot: assert property ( // [R8]
		meas_valid_in && slot != ROM_SLOT_NONE && !slot_enabled[slot]
		|-> !viol_hit)
		else $error("disabled regulator checked");
	chk_index_track: assert property ( // [R9]
		ce_in && meas_valid_in && meas_in.chan == ROM_CH_FIRST
		|=> idx_first == $past(meas_in.idx))
		else $error("channel index not updated");
	chk_debounce_first: assert property ( // [R5]
		cfg[ROM_DEB_BIT] && out_rng && !deb_pend[slot] |-> !viol_hit)
		else $error("debounce let first violation through");
	chk_window_wide: assert property ( // [R7]
		cfg[ROM_THR_HI:ROM_THR_LO] == 2'h0 &&
		diff <= (meas_in.target >> 2) |-> !out_rng)
		else $error("25 percent window too narrow");
endmodule // rom_monitor
`default_nettype wire

/* verif/rom_conv_model.sv */
// Purpose: Converter and regulator side seen by the regulator output monitor.
// Assumes: Requests are issued from the bench on the falling clock edge.
// Notes:   Idle result lines show the inverse of the last result.
`timescale 1ns/1ps
`default_nettype none
module rom_conv_model
	import rom_pkg::*;
(
	// Clock
	input  wire logic                   clk_in,
	// Converter results and regulator states
	output logic                        valid_out,
	output rom_meas_t                   meas_out,
	output logic                        slot_done_out,
	output logic      [ROM_NUM_REG-1:0] on_out
);
	initial begin
		valid_out = 1'b0;
		meas_out = '0;
		slot_done_out = 1'b0;
		on_out = '0;
	end

	// One conversion, valid for exactly one cycle
	task automatic convert(input logic [1:0] c, input logic [2:0] i,
		input logic [7:0] v, input logic [7:0] t);
		@(negedge clk_in);
		valid_out <= 1'b1;
		meas_out <= {c, i, v, t};
		@(negedge clk_in);
		valid_out <= 1'b0;
		meas_out <= ~{c, i, v, t}; // Stale data must never look valid
	endtask

	// Third channel slot finished
	task automatic slot();
		@(negedge clk_in);
		slot_done_out <= 1'b1;
		@(negedge clk_in);
		slot_done_out <= 1'b0;
	endtask

	task automatic power(input logic [ROM_NUM_REG-1:0] v);
		@(negedge clk_in);
		on_out <= v;
	endtask
endmodule // rom_conv_model
`default_nettype wire

/* verif/rom_monitor_tb_top.sv */
// Purpose: Self-checking bench for the regulator output monitor.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Status word is {event, interrupt_n, reset_n, shutdown}.
`timescale 1ns/1ps
`default_nettype none
module rom_monitor_tb_top
	import rom_pkg::*;
;
	logic             clk, rst_n, ce, wr, rd, mask, clr;
	logic [8:0]       addr;
	logic [7:0]       wdata, rdata;
	logic             mv, sdone, ev, irq_n, sys_n;
	rom_meas_t        meas;
	logic [10:0]      on, sd;
	int               fails, checks_done;

	rom_monitor i_rom_monitor (.ref_clk_in(clk), .rst_n_in(rst_n),
		.ce_in(ce), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata), .meas_valid_in(mv),
		.meas_in(meas), .burst_slot_done_in(sdone), .regulator_on_in(on),
		.regulator_shutdown_out(sd), .range_violation_mask_in(mask),
		.event_clear_in(clr), .range_violation_event_out(ev),
		.interrupt_out_n(irq_n), .system_reset_out_n(sys_n));
	rom_conv_model i_rom_conv_model (.clk_in(clk), .valid_out(mv),
		.meas_out(meas), .slot_done_out(sdone), .on_out(on));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic st(input logic [13:0] exp);
		cmp({ev, irq_n, sys_n, sd}, exp);
	endtask

	task automatic wr8(input logic [8:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic rd8(input logic [8:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		cmp({6'h00, rdata}, {6'h00, e});
	endtask

	// Clear event, power cycle all regulators, then configure
	task automatic fresh(input logic [7:0] cfg, input logic [7:0] en);
		@(negedge clk);
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		i_rom_conv_model.power(11'h000);
		i_rom_conv_model.power(11'h7ff);
		wr8(ROM_ADDR_CFG, cfg);
		wr8(ROM_ADDR_EN_C, en);
	endtask

	task automatic t_regs();
		rd8(ROM_ADDR_CFG, 8'h00);
		rd8(ROM_ADDR_IDX_AB, 8'h00);
		rd8(ROM_ADDR_IDX_C, 8'h00);
		wr8(ROM_ADDR_CFG, 8'ha5);
		rd8(ROM_ADDR_CFG, 8'ha5);
		wr8(ROM_ADDR_EN_B, 8'h05);
		rd8(ROM_ADDR_EN_B, 8'h05);
		wr8(ROM_ADDR_IDX_AB, 8'hff);
		rd8(ROM_ADDR_IDX_AB, 8'h00);
		rd8(9'h120, 8'h00);
		$display("test regs done");
	endtask

	task automatic t_lockout();
		fresh(8'h04, 8'h04);
		i_rom_conv_model.convert(2'h0, 3'h1, 8'hff, 8'h80);
		st(14'h3801);
		@(negedge clk);
		mask = 1'b1;
		#1 st(14'h2801);
		@(negedge clk);
		st(14'h2801);
		fresh(8'h04, 8'h04);
		st(14'h1800);
		i_rom_conv_model.convert(2'h0, 3'h1, 8'h00, 8'h80);
		st(14'h2001);
		@(negedge clk);
		st(14'h2801);
		$display("test lockout done");
	endtask

	// Need 0, 1, 2, 4 skipped measurements per delay code
	task automatic t_delay();
		int need[4];
		need = '{0, 1, 2, 4};
		for (int d = 0; d < 4; d++) begin
			fresh({d[1:0], 6'h00}, 8'h04);
			repeat (need[d]) i_rom_conv_model.convert(2'h0, 3'h1, 8'hff, 8'h80);
			st(14'h1800);
			i_rom_conv_model.convert(2'h0, 3'h1, 8'hff, 8'h80);
			st(14'h2801);
		end
		$display("test delay done");
	endtask

	task automatic t_deb();
		fresh(8'h08, 8'h04);
		i_rom_conv_model.convert(2'h0, 3'h1, 8'hff, 8'h80);
		i_rom_conv_model.convert(2'h0, 3'h1, 8'h80, 8'h80);
		i_rom_conv_model.convert(2'h0, 3'h1, 8'hff, 8'h80);
		st(14'h1800);
		i_rom_conv_model.convert(2'h0, 3'h1, 8'hff, 8'h80);
		st(14'h2801);
		$display("test debounce done");
	endtask

	// Edge of each window: exactly on it passes, one beyond fails
	task automatic t_thr();
		logic [7:0] w;
		for (int c = 0; c < 4; c++) begin
			w = 8'h80 >> (2 + c);
			fresh({6'h00, c[1:0]}, 8'h04);
			i_rom_conv_model.convert(2'h0, 3'h1, 8'h80 + w, 8'h80);
			st(14'h1800);
			i_rom_conv_model.convert(2'h0, 3'h1, 8'h7f - w, 8'h80);
			st(14'h2801);
		end
		$display("test threshold done");
	endtask

	task automatic t_modes();
		fresh(8'h10, 8'h00);
		i_rom_conv_model.convert(2'h1, 3'h7, 8'h80, 8'h80);
		st(14'h2800);
		fresh(8'h20, 8'h00);
		i_rom_conv_model.convert(2'h2, 3'h2, 8'h80, 8'h80);
		st(14'h1800);
		i_rom_conv_model.slot();
		st(14'h2800);
		fresh(8'h30, 8'h04);
		i_rom_conv_model.convert(2'h0, 3'h1, 8'hff, 8'h80);
		st(14'h1800);
		fresh(8'h00, 8'h00);
		i_rom_conv_model.convert(2'h0, 3'h1, 8'hff, 8'h80);
		st(14'h1800);
		fresh(8'h00, 8'h04);
		ce = 1'b0;
		i_rom_conv_model.convert(2'h0, 3'h1, 8'hff, 8'h80);
		ce = 1'b1;
		st(14'h1800);
		i_rom_conv_model.convert(2'h1, 3'h3, 8'h80, 8'h80);
		i_rom_conv_model.convert(2'h2, 3'h4, 8'h80, 8'h80);
		rd8(ROM_ADDR_IDX_AB, 8'h31);
		rd8(ROM_ADDR_IDX_C, 8'h04);
		$display("test modes done");
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Whole run is well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		tally_and_finish();
	end

	initial begin
		{rst_n, wr, rd, mask, clr, fails, checks_done} = '0;
		{ce, addr, wdata} = {1'b1, 9'h000, 8'h00};
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		st(14'h1800);
		t_regs();
		t_lockout();
		t_delay();
		t_deb();
		t_thr();
		t_modes();
		tally_and_finish();
	end
endmodule // rom_monitor_tb_top
`default_nettype wire
